// File: bench/stg_spk_model.sv
/* speaker model: times the levels of the tone and amplitude pins.
   assumes plain levels on pclk; it never drives the block. */
`default_nettype none
module stg_spk_model (
    // clock
    input wire logic pclk,
    // pins heard
    input wire logic tone,
    input wire logic amp,
    // measurements
    output logic [15:0] edges = 16'h0,
    output logic [15:0] last_half = 16'h0,
    output logic [15:0] hi_cnt = 16'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev = 1'b0;
    logic [15:0] len = 16'h0;
    // only whole levels are timed; the first after a start may be long
    always @(posedge pclk) begin
        prev <= tone;
        // an unknown level before reset must not poison the count
        hi_cnt <= hi_cnt + ((amp === 1'b1) ? 16'h1 : 16'h0);
        if (tone !== prev) begin
            edges <= edges + 16'h1;
            last_half <= len;
            len <= 16'h1;
        end else begin
            len <= len + 16'h1;
        end
    end
endmodule // stg_spk_model
`default_nettype wire

// File: bench/stg_tone_gen_assertions.sv
/* checker of the tone generator's pins and apb answers.
   assumes a bind into stg_tone_gen; run and route are shadowed from apb. */
`default_nettype none
`include "stg_consts.vh"
module stg_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic plain_tone_out,
    input wire logic shaped_tone_out,
    input wire logic amplitude_out,
    input wire logic clock_out_pin,
    input wire logic amplitude_pin_released
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_r;
    logic route_r;
    wire acc = psel && penable;
    wire hit = paddr == `STG_ADDR_CONTROL || paddr == `STG_ADDR_AMPLITUDE
        || paddr == `STG_ADDR_DIVIDER;
    // control bits are not pins, so they are rebuilt from the writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
            route_r <= 1'b0;
        end else if (acc && pwrite && paddr == `STG_ADDR_CONTROL) begin
            run_r <= pwdata[`STG_CTL_RUN];
            route_r <= pwdata[`STG_CTL_ROUTE];
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // pins lag the register by up to two cycles, hence four samples
    a_stop_low: assert property (
        !run_r [*4] |-> !(plain_tone_out || shaped_tone_out
        || amplitude_out || clock_out_pin)) else $error("pin high, stopped");
    a_ready_high: assert property (
        acc |-> pready) else $error("access stalled");
    a_err_unmapped: assert property (
        acc && !hit |-> pslverr) else $error("no error on hole");
    a_err_mapped: assert property (
        acc && hit |-> !pslverr) else $error("error on register");
    a_read_zero: assert property (
        acc && !pwrite && !hit |-> prdata == 32'h0) else $error("hole data");
    a_route_rel: assert property (
        route_r [*4] |-> amplitude_pin_released) else $error("pin kept");
    a_route_zero: assert property (
        (run_r && !route_r) [*4] |-> !shaped_tone_out && !clock_out_pin)
        else $error("route zero leak");
    a_route_one: assert property (
        (run_r && route_r) [*4] |-> !plain_tone_out && !amplitude_out)
        else $error("route one leak");
    cover property (run_r && !route_r && plain_tone_out);
    cover property (run_r && route_r && shaped_tone_out);
    cover property (acc && !hit);
endmodule // stg_chk
bind stg_tone_gen stg_chk u_chk (.*);
`default_nettype wire

// File: bench/stg_tone_gen_tb.sv
/* self-checking bench of the tone generator.
   assumes the speaker model and the bound checker beside the block. */
`default_nettype none
`include "stg_consts.vh"
module stg_tone_gen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, plain, shaped, ampo, clko, rel;
    wire [15:0] edges, half, hi;
    int n_fail = 0;
    int compares = 0;
    stg_tone_gen u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .plain_tone_out(plain), .shaped_tone_out(shaped),
        .amplitude_out(ampo), .clock_out_pin(clko),
        .amplitude_pin_released(rel));
    stg_spk_model u_spk (.pclk(pclk), .tone(plain | shaped), .amp(ampo),
        .edges(edges), .last_half(half), .hi_cnt(hi));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task close_out;
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [17:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 8'h0);
        chk(nm, e, q);
    endtask
    task ctl(input logic [7:0] v);
        apb(1'b1, `STG_ADDR_CONTROL, v);
    endtask
    task wait_edges(input int n);
        int t0;
        t0 = edges;
        repeat (40000) begin
            @(posedge pclk);
            if (int'(edges) - t0 >= n) break;
        end
    endtask
    task t_regs;
        rd(`STG_ADDR_CONTROL, 32'h0, "control");
        rd(`STG_ADDR_AMPLITUDE, 32'h0, "amplitude");
        rd(`STG_ADDR_DIVIDER, 32'h0, "divider");
        rd(18'h0, 32'h0, "hole_data");
        chk("hole_err", 32'h1, {31'h0, err});
        apb(1'b1, `STG_ADDR_AMPLITUDE, 8'hff);
        rd(`STG_ADDR_AMPLITUDE, 32'h7f, "amp_mask");
        apb(1'b1, `STG_ADDR_DIVIDER, 8'hff);
        rd(`STG_ADDR_DIVIDER, 32'hf, "div_mask");
        ctl(8'h7f);
        rd(`STG_ADDR_CONTROL, 32'hf, "ctl_mask");
    endtask
    task t_tone(input logic cs, input logic [1:0] pre, input logic [3:0] dv);
        int e;
        logic [7:0] c;
        e = (int'(dv) + 17) << (5 + pre);
        if (!cs) e = e * 2;
        c = {5'h0, pre, cs};
        apb(1'b1, `STG_ADDR_DIVIDER, {4'h0, dv});
        ctl(c);
        ctl(c | 8'h80);
        wait_edges(2);
        chk("half_period", e, half);
        ctl(c);
        repeat (4) @(posedge pclk);
        chk("stopped", 32'h0, {28'h0, plain, shaped, ampo, clko});
    endtask
    task t_pwm;
        logic [15:0] h0;
        logic [15:0] d;
        logic [6:0] codes [3];
        codes = '{7'h0, 7'h3, 7'h7f};
        ctl(8'h01);
        ctl(8'h81);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `STG_ADDR_AMPLITUDE, {1'b0, codes[k]});
            repeat (4200) @(posedge pclk);
            h0 = hi;
            repeat (4096) @(posedge pclk);
            d = hi - h0;
            chk("duty", codes[k] == 0 ? 0 : (codes[k] + 1) * 32, d);
        end
        ctl(8'h01);
    endtask
    task t_route;
        int e0;
        logic b;
        apb(1'b1, `STG_ADDR_DIVIDER, 8'h0);
        ctl(8'h09);
        ctl(8'h89);
        wait_edges(3);
        chk("shaped_half", 32'd544, half);
        chk("released", 32'h1, {31'h0, rel});
        @(posedge pclk);
        b = clko;
        @(posedge pclk);
        chk("clock_out", {31'h0, ~b}, {31'h0, clko});
        apb(1'b1, `STG_ADDR_AMPLITUDE, 8'h00);
        repeat (4200) @(posedge pclk);
        e0 = edges;
        repeat (2200) @(posedge pclk);
        chk("shaped_quiet", e0, edges);
        ctl(8'h09);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        for (int p = 0; p < 4; p++) t_tone(1'b1, 2'(p), 4'd0);
        t_tone(1'b0, 2'd0, 4'hf);
        t_tone(1'b0, 2'd3, 4'd0);
        t_pwm;
        t_route;
        close_out;
    end
    // the scenarios need some 71k cycles; the limit stays under 100k
    initial begin
        #900us;
        n_fail++;
        close_out;
    end
endmodule // stg_tone_gen_tb
`default_nettype wire

// File: design/stg_prescaler.v
/*
 * two-stage prescaler of the tone generator: half or full system clock,
 * then a divide by 2^5..2^8; produces a one-cycle tick per output period.
 * assumes a single clock domain and a synchronous clear from the core.
 */
`default_nettype none
`include "stg_consts.vh"

module stg_prescaler (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire run,
    input wire clk_sel,
    input wire [1:0] pre_sel,
    // tick
    output wire tick
);
    // ten bits: half clock with the 2^8 stage needs a count of 512
    reg [9:0] cnt_r;
    reg [9:0] cnt_nxt;
    reg [9:0] limit;

    // stage one halves unless clk_sel is set, stage two divides by 2^(5+sel)
    always @* begin
        limit = 10'h000;
        case (pre_sel)
            2'b00: limit = 10'h020;
            2'b01: limit = 10'h040;
            2'b10: limit = 10'h080;
            default: limit = 10'h100;
        endcase
        if (!clk_sel) begin
            limit = {limit[8:0], 1'b0};
        end
    end

    assign tick = run && (cnt_r == limit - 10'h001);

    always @* begin
        if (!run || tick) begin
            cnt_nxt = 10'h000;
        end else begin
            cnt_nxt = cnt_r + 10'h001;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 10'h000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // stg_prescaler

`default_nettype wire

// File: design/stg_pwm.v
/*
 * 7-bit amplitude pwm: a 128-step period counted on the prescaler tick.
 * assumes tick is a one-cycle pulse from the same clock.
 */
`default_nettype none
`include "stg_consts.vh"

module stg_pwm (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire run,
    input wire tick,
    input wire [6:0] duty,
    // output
    output reg pwm_r
);
    reg [6:0] pos_r;

    // code 0 gives 0/128, code n gives (n+1)/128, all ones 128/128
    function high_at;
        input [6:0] code;
        input [6:0] pos;
        begin
            high_at = (code != 7'h00) && ({1'b0, pos} <= {1'b0, code});
        end
    endfunction

    // duty is read live: a write mid-period may stretch one high phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r <= 7'h00;
            pwm_r <= 1'b0;
        end else if (!run) begin
            pos_r <= 7'h00;
            pwm_r <= 1'b0;
        end else begin
            if (tick) begin
                pos_r <= pos_r + 7'h01;
            end
            pwm_r <= high_at(duty, pos_r);
        end
    end
endmodule // stg_pwm

`default_nettype wire

// File: design/stg_tone_gen.v
/*
 * tone generator top: apb register slave, tone divider and output routing.
 * assumes an apb master on pclk; pins are driven directly by flip-flops.
 */
`default_nettype none
`include "stg_consts.vh"

// How it works
// - run bit clear halts and lows outputs except the release flag
// - run bit set drives selected outputs
// - route bit picks plain+amplitude or shaped+clock
// - prescale field divides by 2^5..2^8
// - clock select picks half or full
// - tone equals fx over divider+17, scaled
// - divider four bits, resets zero
// - amplitude code sets pwm duty
// - amplitude writes accepted while running
// - route zero outputs plain tone and amplitude
// - route one outputs shaped tone, releases pin
// - shaped tone is tone and pwm
// - eight-bit and five-bit counters
module stg_tone_gen (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // pins
    output reg plain_tone_out,
    output reg shaped_tone_out,
    output reg amplitude_out,
    output reg clock_out_pin,
    output reg amplitude_pin_released
);
    reg [7:0] tone_control_r;
    reg [7:0] amplitude_duty_r;
    reg [7:0] tone_divider_r;
    reg [7:0] tone_cnt_r;
    reg [7:0] tone_cnt_nxt;
    reg [4:0] slow_cnt_r;
    reg tone_r;
    reg clk_div_r;
    wire run;
    wire route;
    wire tick;
    wire pwm;
    wire wr_en;
    wire rd_en;
    wire addr_hit;

    assign run = tone_control_r[`STG_CTL_RUN];
    assign route = tone_control_r[`STG_CTL_ROUTE];

    // apb: zero wait states; unmapped addresses answer with pslverr
    assign pready = 1'b1;
    assign addr_hit = (paddr == `STG_ADDR_CONTROL) ||
                      (paddr == `STG_ADDR_AMPLITUDE) ||
                      (paddr == `STG_ADDR_DIVIDER);
    assign pslverr = psel && penable && !addr_hit;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_control_r <= `STG_RST_CONTROL;
            amplitude_duty_r <= `STG_RST_AMPLITUDE;
            tone_divider_r <= `STG_RST_DIVIDER;
        end else if (wr_en) begin
            case (paddr)
                // bits 4..6 kept zero in hardware too
                `STG_ADDR_CONTROL:
                    tone_control_r <= pwdata[7:0] & 8'h8f;
                // amplitude takes effect at once, no stop needed
                `STG_ADDR_AMPLITUDE:
                    amplitude_duty_r <= {1'b0, pwdata[6:0]};
                `STG_ADDR_DIVIDER:
                    tone_divider_r <= {4'h0, pwdata[3:0]};
                default: tone_control_r <= tone_control_r;
            endcase
        end
    end

    // read data registered in setup so it is stable in access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                `STG_ADDR_CONTROL: prdata <= {24'h000000, tone_control_r};
                `STG_ADDR_AMPLITUDE:
                    prdata <= {24'h000000, amplitude_duty_r};
                `STG_ADDR_DIVIDER: prdata <= {24'h000000, tone_divider_r};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    stg_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .clk_sel(tone_control_r[`STG_CTL_CLK_SEL]),
        .pre_sel({tone_control_r[`STG_CTL_PRE_HI],
                  tone_control_r[`STG_CTL_PRE_LO]}),
        .tick(tick)
    );

    stg_pwm u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .tick(tick),
        .duty(amplitude_duty_r[6:0]),
        .pwm_r(pwm)
    );

    // 8-bit counter: half period is divider+17 ticks; the 5-bit counter
    // counts half periods so a full tone cycle is 2*(n+17) ticks
    always @* begin
        if (!run) begin
            tone_cnt_nxt = 8'h00;
        end else if (tick && tone_cnt_r ==
                     tone_divider_r + `STG_DIV_OFFSET - 8'h01) begin
            tone_cnt_nxt = 8'h00;
        end else if (tick) begin
            tone_cnt_nxt = tone_cnt_r + 8'h01;
        end else begin
            tone_cnt_nxt = tone_cnt_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_cnt_r <= 8'h00;
            slow_cnt_r <= 5'h00;
            tone_r <= 1'b0;
            clk_div_r <= 1'b0;
        end else if (!run) begin
            tone_cnt_r <= 8'h00;
            slow_cnt_r <= 5'h00;
            tone_r <= 1'b0;
            clk_div_r <= 1'b0;
        end else begin
            tone_cnt_r <= tone_cnt_nxt;
            clk_div_r <= ~clk_div_r;
            if (tick && tone_cnt_nxt == 8'h00) begin
                tone_r <= ~tone_r;
                slow_cnt_r <= slow_cnt_r + 5'h01;
            end
        end
    end

    // outputs registered; a stop forces all but amplitude_pin_released low the next edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            plain_tone_out <= 1'b0;
            shaped_tone_out <= 1'b0;
            amplitude_out <= 1'b0;
            clock_out_pin <= 1'b0;
            amplitude_pin_released <= 1'b0;
        end else if (!run) begin
            plain_tone_out <= 1'b0;
            shaped_tone_out <= 1'b0;
            amplitude_out <= 1'b0;
            clock_out_pin <= 1'b0;
            amplitude_pin_released <= route;
        end else if (!route) begin
            plain_tone_out <= tone_r;
            amplitude_out <= pwm;
            shaped_tone_out <= 1'b0;
            clock_out_pin <= 1'b0;
            amplitude_pin_released <= 1'b0;
        end else begin
            shaped_tone_out <= tone_r & pwm;
            clock_out_pin <= clk_div_r;
            plain_tone_out <= 1'b0;
            amplitude_out <= 1'b0;
            amplitude_pin_released <= 1'b1;
        end
    end
endmodule // stg_tone_gen

`default_nettype wire

// File: include/stg_consts.vh
/*
 * constants of the tone generator: register offsets, field positions,
 * reset values and counter geometry.
 * assumes inclusion by bare name from the design files.
 */
`ifndef STG_CONSTS_VH
`define STG_CONSTS_VH

// register indices are not word aligned, so each byte address is index*4
`define STG_IDX_CONTROL 16'hffc0
`define STG_IDX_AMPLITUDE 16'hffc1
`define STG_IDX_DIVIDER 16'hffc2
`define STG_ADDR_CONTROL 18'h3ff00
`define STG_ADDR_AMPLITUDE 18'h3ff04
`define STG_ADDR_DIVIDER 18'h3ff08

// reset values
`define STG_RST_CONTROL 8'h00
`define STG_RST_AMPLITUDE 8'h00
`define STG_RST_DIVIDER 8'h00

// control fields
`define STG_CTL_CLK_SEL 0
`define STG_CTL_PRE_LO 1
`define STG_CTL_PRE_HI 2
`define STG_CTL_ROUTE 3
`define STG_CTL_RUN 7

// counters and divider geometry
`define STG_DIV_OFFSET 8'h11
`define STG_PRE_BASE 5
`define STG_PWM_STEPS 8'h80

`endif
